// ===== clp_consts.vh
`ifndef CLP_CONSTS_VH
`define CLP_CONSTS_VH
// clock and execution times
`define CLP_CLK_NS 20
`define CLP_FOSC_KHZ 270
`define CLP_T_LONG_NS 1520000
`define CLP_T_SHORT_NS 38000
`define CLP_LONG_CYC ((`CLP_T_LONG_NS + `CLP_CLK_NS - 1) / `CLP_CLK_NS)
`define CLP_SHORT_CYC ((`CLP_T_SHORT_NS + `CLP_CLK_NS - 1) / `CLP_CLK_NS)
// instruction field positions
`define CLP_B_DIR 1
`define CLP_B_SH 0
`define CLP_B_DON 2
`define CLP_B_CUR 1
`define CLP_B_BLK 0
`define CLP_B_SC 3
`define CLP_B_RL 2
`define CLP_B_DL 4
`define CLP_B_N 3
`define CLP_B_F 2
// reset values
`define CLP_RST_DL 1'b1
`define CLP_RST_DIR 1'b1
`define CLP_RST_AC 7'h00
`define CLP_RST_LATCH 8'h00
// text ram layout and queue depth
`define CLP_SPACE 8'h20
`define CLP_L1_END 7'h27
`define CLP_L2_BASE 7'h40
`define CLP_L2_END 7'h67
`define CLP_ONE_END 7'h4f
`define CLP_TXT_LAST 7'h7f
`define CLP_LINE_LEN 7'd40
`define CLP_ONE_LEN 7'd80
`define CLP_FIFO_DEPTH 4
`endif

// ===== clp_instruction_port.v
`timescale 1ns/10ps
`include "clp_consts.vh"

module clp_fifo #(
  parameter W = 8,
  parameter D = `CLP_FIFO_DEPTH,
  parameter AW = 2
) (
  // clock and reset
  input wire mclk,
  input wire reset,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  // drain side
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wr_reg;
  reg [AW-1:0] rd_reg;
  reg [AW:0] cnt_reg;
  wire push;
  wire pop;

  assign in_ready = (cnt_reg != D[AW:0]);
  assign out_valid = (cnt_reg != {(AW+1){1'b0}});
  assign out_data = mem[rd_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always @(posedge mclk) begin
    if (push) begin
      mem[wr_reg] <= in_data;
    end
  end

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      wr_reg <= {AW{1'b0}};
      rd_reg <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_reg + 1'b1;
      end
      if (push & ~pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop & ~push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule // clp_fifo

////////////////////////////////////////////////////////////////////////////////

module clp_instruction_port #(
  parameter LONG_CYC = `CLP_LONG_CYC,
  parameter SHORT_CYC = `CLP_SHORT_CYC
) (
  // clock and reset
  input wire mclk,
  input wire reset,
  // host pins
  input wire bus_strobe,
  input wire register_select,
  input wire read_write,
  input wire [7:0] host_data_bus_in,
  output reg [7:0] host_data_bus_out,
  output wire host_data_bus_oe,
  // state
  output wire busy_indicator,
  output wire data_write_ready,
  output reg display_on_reg,
  output reg cursor_on_reg,
  output reg cursor_blink_reg,
  output reg entry_increment_reg,
  output reg entry_shift_reg,
  output reg bus_width_select,
  output reg two_line_reg,
  output reg font_tall_reg,
  output reg [6:0] display_shift_reg,
  output reg [6:0] address_counter,
  // display scan
  input wire scan_line,
  input wire [3:0] scan_col,
  input wire [3:0] scan_row,
  output reg [4:0] scan_pixels_reg
);
  localparam ST_IDLE = 2'd0;
  localparam ST_RUN = 2'd1;
  localparam ST_CLEAR = 2'd2;

  reg [7:0] text_ram [0:127];
  reg [7:0] custom_glyph_ram [0:63];
  reg [1:0] state_reg;
  reg [16:0] timer_reg;
  reg [6:0] clr_idx_reg;
  reg [7:0] instruction_reg;
  reg [7:0] data_latch_reg;
  reg glyph_sel_reg;
  reg [2:0] e_sync_reg;
  reg [1:0] rs_sync_reg;
  reg [1:0] rw_sync_reg;
  reg [7:0] db_s1_reg;
  reg [7:0] db_s2_reg;
  reg phase_reg;
  reg [3:0] hi_nib_reg;
  reg done_reg;
  reg done_rs_reg;
  reg done_rw_reg;
  reg [7:0] byte_reg;
  reg [7:0] bus_sel;
  reg [6:0] scan_addr;
  reg [7:0] scan_code;

  wire idle = (state_reg == ST_IDLE);
  wire fifo_valid;
  wire [7:0] fifo_data;
  wire strobe_fall = e_sync_reg[2] & ~e_sync_reg[1];
  wire pop = idle & fifo_valid;
  wire ins_go = idle & ~fifo_valid & done_reg & ~done_rs_reg & ~done_rw_reg;
  wire rd_go = idle & ~fifo_valid & done_reg & done_rs_reg & done_rw_reg;
  // ram choice and line mode go in as arguments so these nets follow them
  wire [6:0] ac_next = step_ac(address_counter, entry_increment_reg, glyph_sel_reg,
    two_line_reg);
  wire [6:0] ac_shift = step_ac(address_counter, byte_reg[`CLP_B_RL], glyph_sel_reg,
    two_line_reg);
  wire clearing = (state_reg == ST_CLEAR);

  // counter step with line wrap
  function [6:0] step_ac;
    input [6:0] ac;
    input up;
    input glyph;
    input two;
    begin
      if (glyph) begin
        step_ac = {1'b0, up ? ac[5:0] + 6'd1 : ac[5:0] - 6'd1};
      end else if (two) begin
        if (up) begin
          step_ac = (ac == `CLP_L1_END) ? `CLP_L2_BASE :
            (ac == `CLP_L2_END) ? 7'h00 : ac + 7'd1;
        end else begin
          step_ac = (ac == 7'h00) ? `CLP_L2_END :
            (ac == `CLP_L2_BASE) ? `CLP_L1_END : ac - 7'd1;
        end
      end else begin
        step_ac = up ? ((ac == `CLP_ONE_END) ? 7'h00 : ac + 7'd1) :
          ((ac == 7'h00) ? `CLP_ONE_END : ac - 7'd1);
      end
    end
  endfunction

  // display window offset, wraps at the line length
  function [6:0] step_shift;
    input [6:0] s;
    input left;
    reg [6:0] len;
    begin
      len = two_line_reg ? `CLP_LINE_LEN : `CLP_ONE_LEN;
      if (left) begin
        step_shift = (s == len - 7'd1) ? 7'h00 : s + 7'd1;
      end else begin
        step_shift = (s == 7'h00) ? len - 7'd1 : s - 7'd1;
      end
    end
  endfunction

  // stand-in pattern generator; the production font table replaces it
  function [4:0] fixed_glyph_rom;
    input [7:0] code;
    input [3:0] row;
    reg [7:0] r;
    begin
      r = code ^ {row, row};
      fixed_glyph_rom = (row > (font_tall_reg ? 4'd9 : 4'd7)) ? 5'h00 : r[4:0];
    end
  endfunction

  clp_fifo #(
    .W(8),
    .D(`CLP_FIFO_DEPTH),
    .AW(2)
  ) u_fifo (
    .mclk(mclk),
    .reset(reset),
    .in_valid(done_reg & done_rs_reg & ~done_rw_reg),
    .in_ready(data_write_ready),
    .in_data(byte_reg),
    .out_valid(fifo_valid),
    .out_ready(idle),
    .out_data(fifo_data)
  );

  assign busy_indicator = ~idle | fifo_valid;
  assign host_data_bus_oe = e_sync_reg[1] & rw_sync_reg[1];

  ////////////////////////////////////////////////////////////////////////////////
  // pin capture

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      e_sync_reg <= 3'b000;
      rs_sync_reg <= 2'b00;
      rw_sync_reg <= 2'b00;
      db_s1_reg <= 8'h00;
      db_s2_reg <= 8'h00;
      phase_reg <= 1'b0;
      hi_nib_reg <= 4'h0;
      done_reg <= 1'b0;
      done_rs_reg <= 1'b0;
      done_rw_reg <= 1'b0;
      byte_reg <= 8'h00;
    end else begin
      e_sync_reg <= {e_sync_reg[1:0], bus_strobe};
      rs_sync_reg <= {rs_sync_reg[0], register_select};
      rw_sync_reg <= {rw_sync_reg[0], read_write};
      db_s1_reg <= host_data_bus_in;
      db_s2_reg <= db_s1_reg;
      done_reg <= 1'b0;
      if (strobe_fall) begin
        done_rs_reg <= rs_sync_reg[1];
        done_rw_reg <= rw_sync_reg[1];
        if (bus_width_select) begin
          phase_reg <= 1'b0;
          byte_reg <= db_s2_reg;
          done_reg <= 1'b1;
        end else if (!phase_reg) begin
          phase_reg <= 1'b1;
          hi_nib_reg <= db_s2_reg[7:4];
        end else begin
          phase_reg <= 1'b0;
          byte_reg <= {hi_nib_reg, db_s2_reg[7:4]};
          done_reg <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read bus

  always @* begin
    bus_sel = {busy_indicator, address_counter};
    if (rs_sync_reg[1]) begin
      bus_sel = data_latch_reg;
    end
    if (!bus_width_select) begin
      bus_sel = {phase_reg ? bus_sel[3:0] : bus_sel[7:4], 4'h0};
    end
  end

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      host_data_bus_out <= 8'h00;
    end else begin
      host_data_bus_out <= bus_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // ram write ports

  always @(posedge mclk) begin
    if (clearing) begin
      text_ram[clr_idx_reg] <= `CLP_SPACE;
    // data write to the targeted ram
    end else if (pop & ~glyph_sel_reg) begin
      text_ram[address_counter] <= fifo_data;
    end
    if (pop & glyph_sel_reg) begin
      custom_glyph_ram[address_counter[5:0]] <= fifo_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // executor

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      timer_reg <= 17'd0;
      clr_idx_reg <= 7'h00;
      instruction_reg <= 8'h00;
      data_latch_reg <= `CLP_RST_LATCH;
      glyph_sel_reg <= 1'b0;
      address_counter <= `CLP_RST_AC;
      display_on_reg <= 1'b0;
      cursor_on_reg <= 1'b0;
      cursor_blink_reg <= 1'b0;
      entry_increment_reg <= `CLP_RST_DIR;
      entry_shift_reg <= 1'b0;
      bus_width_select <= `CLP_RST_DL;
      two_line_reg <= 1'b0;
      font_tall_reg <= 1'b0;
      display_shift_reg <= 7'h00;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (pop) begin
            address_counter <= ac_next;
            if (entry_shift_reg & ~glyph_sel_reg) begin
              display_shift_reg <= step_shift(display_shift_reg, entry_increment_reg);
            end
            timer_reg <= SHORT_CYC[16:0];
            state_reg <= ST_RUN;
          end else if (rd_go) begin
            address_counter <= ac_next;
            data_latch_reg <= glyph_sel_reg ? custom_glyph_ram[ac_next[5:0]] :
              text_ram[ac_next];
            timer_reg <= SHORT_CYC[16:0];
            state_reg <= ST_RUN;
          end else if (ins_go) begin
            instruction_reg <= byte_reg;
            timer_reg <= SHORT_CYC[16:0];
            state_reg <= ST_RUN;
            if (byte_reg[7]) begin
              address_counter <= byte_reg[6:0];
              glyph_sel_reg <= 1'b0;
              data_latch_reg <= text_ram[byte_reg[6:0]];
            end else if (byte_reg[6]) begin
              address_counter <= {1'b0, byte_reg[5:0]};
              glyph_sel_reg <= 1'b1;
              data_latch_reg <= custom_glyph_ram[byte_reg[5:0]];
            end else if (byte_reg[5]) begin
              bus_width_select <= byte_reg[`CLP_B_DL];
              two_line_reg <= byte_reg[`CLP_B_N];
              font_tall_reg <= byte_reg[`CLP_B_F];
            end else if (byte_reg[4]) begin
              if (byte_reg[`CLP_B_SC]) begin
                display_shift_reg <= step_shift(display_shift_reg, ~byte_reg[`CLP_B_RL]);
              end else begin
                address_counter <= ac_shift;
                data_latch_reg <= text_ram[ac_shift];
              end
            end else if (byte_reg[3]) begin
              display_on_reg <= byte_reg[`CLP_B_DON];
              cursor_on_reg <= byte_reg[`CLP_B_CUR];
              cursor_blink_reg <= byte_reg[`CLP_B_BLK];
            end else if (byte_reg[2]) begin
              entry_increment_reg <= byte_reg[`CLP_B_DIR];
              entry_shift_reg <= byte_reg[`CLP_B_SH];
            end else if (byte_reg[1]) begin
              address_counter <= 7'h00;
              glyph_sel_reg <= 1'b0;
              display_shift_reg <= 7'h00;
              timer_reg <= LONG_CYC[16:0];
            end else if (byte_reg[0]) begin
              // clear, 1.52ms, entry back to increment
              address_counter <= 7'h00;
              glyph_sel_reg <= 1'b0;
              display_shift_reg <= 7'h00;
              entry_increment_reg <= 1'b1;
              clr_idx_reg <= 7'h00;
              timer_reg <= LONG_CYC[16:0];
              state_reg <= ST_CLEAR;
            end
          end
        end
        ST_CLEAR: begin
          // fill takes 128 cycles, well inside the timed window
          timer_reg <= timer_reg - 17'd1;
          clr_idx_reg <= clr_idx_reg + 7'd1;
          if (clr_idx_reg == `CLP_TXT_LAST) begin
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          // busy held for the full time
          timer_reg <= timer_reg - 17'd1;
          if (timer_reg <= 17'd1) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // display scan

  always @* begin
    if (two_line_reg) begin
      scan_addr = (({3'b000, scan_col} + display_shift_reg) % `CLP_LINE_LEN) +
        (scan_line ? `CLP_L2_BASE : 7'h00);
    end else begin
      scan_addr = ({3'b000, scan_col} + display_shift_reg) % `CLP_ONE_LEN;
    end
    scan_code = text_ram[scan_addr];
  end

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      scan_pixels_reg <= 5'h00;
    end else if (scan_code[7:4] == 4'h0) begin
      // custom glyph row, code bit 3 ignored
      scan_pixels_reg <= custom_glyph_ram[{scan_code[2:0], scan_row[2:0]}][4:0];
    end else begin
      scan_pixels_reg <= fixed_glyph_rom(scan_code, scan_row);
    end
  end
endmodule // clp_instruction_port

// ===== clp_port_asserts.sv
`timescale 1ns/10ps
module clp_port_asserts #(
  parameter LONG_CYC = 200,
  parameter SHORT_CYC = 40
) (
  // clock and reset
  input wire mclk,
  input wire reset,
  // host pins
  input wire bus_strobe,
  input wire register_select,
  input wire read_write,
  input wire [7:0] host_data_bus_out,
  input wire host_data_bus_oe,
  // state
  input wire busy_indicator,
  input wire data_write_ready,
  input wire display_on_reg,
  input wire cursor_on_reg,
  input wire cursor_blink_reg,
  input wire bus_width_select,
  input wire two_line_reg,
  input wire font_tall_reg,
  input wire [6:0] address_counter
);
  localparam int BUSY_MAX = LONG_CYC + 8 * SHORT_CYC;
  reg [17:0] run_reg;
  reg [7:0] since_fall_reg;
  reg strobe_d_reg;
  wire [5:0] cfg = {display_on_reg, cursor_on_reg, cursor_blink_reg, bus_width_select,
    two_line_reg, font_tall_reg};
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
////////////////////////////////////////////////////////////////////////////////
  // busy run length and age of the last strobe fall at the pin
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      run_reg <= 18'h00000;
      since_fall_reg <= 8'hff;
      strobe_d_reg <= 1'b0;
    end else begin
      run_reg <= busy_indicator ? run_reg + 18'h00001 : 18'h00000;
      strobe_d_reg <= bus_strobe;
      if (strobe_d_reg && !bus_strobe) begin
        since_fall_reg <= 8'h00;
      end else if (since_fall_reg != 8'hff) begin
        since_fall_reg <= since_fall_reg + 8'h01;
      end
    end
  end
////////////////////////////////////////////////////////////////////////////////
  sequence read_held;
    (bus_strobe && read_write) [*3];
  endsequence
  sequence write_held;
    (bus_strobe && !read_write) [*3];
  endsequence
  // select and direction must have settled through the synchronizers
  sequence status_view;
    host_data_bus_oe && bus_width_select && !register_select && read_write
      && $past(register_select, 4) == 1'b0 && $past(read_write, 4) == 1'b1;
  endsequence
  chk_status_busy: assert property (
    status_view |-> host_data_bus_out[7] == $past(busy_indicator))
    else $error("status busy bit wrong");
  chk_status_count: assert property (
    status_view |-> host_data_bus_out[6:0] == $past(address_counter))
    else $error("status counter bits wrong");
  chk_oe_read: assert property (read_held |=> host_data_bus_oe)
    else $error("bus not driven on read");
  chk_oe_write: assert property (write_held |=> !host_data_bus_oe)
    else $error("bus driven on write");
  chk_busy_min: assert property ($fell(busy_indicator) |-> run_reg >= SHORT_CYC)
    else $error("busy too short");
  chk_busy_bound: assert property (busy_indicator |-> run_reg < BUSY_MAX)
    else $error("busy too long");
  chk_busy_cause: assert property ($rose(busy_indicator) |-> since_fall_reg <= 8'h08)
    else $error("busy without strobe");
  chk_cfg_quiet: assert property ((!bus_strobe) [*8] |-> $stable(cfg))
    else $error("settings changed without instruction");
  chk_count_quiet: assert property (
    (!bus_strobe && !busy_indicator) [*8] |-> $stable(address_counter))
    else $error("counter moved while idle");
  chk_full_busy: assert property (!data_write_ready |-> busy_indicator)
    else $error("queue full while idle");
  // a data write ends with the strobe falling while the queue has room
  sequence data_write_done;
    (bus_strobe && register_select && !read_write && bus_width_select) ##1
      (!bus_strobe && data_write_ready);
  endsequence
  chk_write_busy: assert property (data_write_done |-> ##[1:6] busy_indicator)
    else $error("data write not taken");
  cover property (!data_write_ready);
endmodule // clp_port_asserts

bind clp_instruction_port clp_port_asserts #(.LONG_CYC(LONG_CYC), .SHORT_CYC(SHORT_CYC))
  clp_port_asserts_inst (.mclk(mclk), .reset(reset), .bus_strobe(bus_strobe),
  .register_select(register_select), .read_write(read_write),
  .host_data_bus_out(host_data_bus_out), .host_data_bus_oe(host_data_bus_oe),
  .busy_indicator(busy_indicator), .data_write_ready(data_write_ready),
  .display_on_reg(display_on_reg), .cursor_on_reg(cursor_on_reg),
  .cursor_blink_reg(cursor_blink_reg), .bus_width_select(bus_width_select),
  .two_line_reg(two_line_reg), .font_tall_reg(font_tall_reg),
  .address_counter(address_counter));

// ===== clp_host_model.sv
`timescale 1ns/10ps
module clp_host_model (
  // clock
  input wire mclk,
  // host pins
  output reg bus_strobe,
  output reg register_select,
  output reg read_write,
  output wire [7:0] host_data_bus_in,
  // device side of the bus
  input wire [7:0] host_data_bus_out,
  input wire host_data_bus_oe
);
  reg drive_reg = 1'b0;
  reg [7:0] drv_val = 8'h00;
  reg [7:0] last_reg = 8'h00;
  // nobody driving: the float changes every cycle so stale data never matches
  assign host_data_bus_in = host_data_bus_oe ? host_data_bus_out :
    (drive_reg ? drv_val : ~last_reg);
  always @(posedge mclk) last_reg <= host_data_bus_in;
  initial begin
    bus_strobe = 1'b0;
    register_select = 1'b0;
    read_write = 1'b1;
  end
////////////////////////////////////////////////////////////////////////////////
  // setup, strobe, hold
  task automatic xfer(input logic sel, input logic rw, input logic [7:0] d, input int hi,
      output logic [7:0] q);
    @(posedge mclk);
    #1;
    register_select = sel;
    read_write = rw;
    drv_val = d;
    drive_reg = !rw;
    @(posedge mclk);
    #1;
    bus_strobe = 1'b1;
    repeat (hi) @(posedge mclk);
    #1;
    q = host_data_bus_in;
    bus_strobe = 1'b0;
    repeat (5) @(posedge mclk);
    #1;
    drive_reg = 1'b0;
  endtask
  task automatic wait_idle(output logic ok);
    logic [7:0] s;
    ok = 1'b0;
    for (int i = 0; i < 400 && !ok; i++) begin
      xfer(1'b0, 1'b1, 8'h00, 8, s);
      ok = (s[7] === 1'b0);
    end
  endtask
endmodule // clp_host_model

// ===== test_clp_instruction_port.sv
`timescale 1ns/10ps
module test_clp_instruction_port;
  localparam int SHORT = 40;
  localparam int LONG = 200;
  reg mclk = 1'b0;
  reg reset = 1'b1;
  reg [8:0] scan_reg = 9'h000;
  reg saw_full = 1'b0;
  reg [31:0] seed = 32'h0000005d;
  reg [7:0] mem [0:3];
  reg [7:0] q;
  reg [7:0] a;
  int k;
  int n_errors = 0;
  int n_compared = 0;
  wire strobe, sel, rdwr, oe, busy, wready, dsp, cur, blk, inc, esh, bw, two, tall;
  wire [7:0] din;
  wire [7:0] dout;
  wire [6:0] dshift;
  wire [6:0] cnt;
  wire [4:0] pix;
  always #10 mclk = ~mclk;
  always @(posedge mclk) scan_reg <= scan_reg + 9'h001;
  always @(posedge mclk) if (!wready && !reset) saw_full <= 1'b1;
  clp_instruction_port #(.LONG_CYC(LONG), .SHORT_CYC(SHORT)) clp_instruction_port_inst (
    .mclk(mclk), .reset(reset), .bus_strobe(strobe), .register_select(sel),
    .read_write(rdwr), .host_data_bus_in(din), .host_data_bus_out(dout),
    .host_data_bus_oe(oe), .busy_indicator(busy), .data_write_ready(wready),
    .display_on_reg(dsp), .cursor_on_reg(cur), .cursor_blink_reg(blk),
    .entry_increment_reg(inc), .entry_shift_reg(esh), .bus_width_select(bw),
    .two_line_reg(two), .font_tall_reg(tall), .display_shift_reg(dshift),
    .address_counter(cnt), .scan_line(scan_reg[8]), .scan_col(scan_reg[3:0]),
    .scan_row(scan_reg[7:4]), .scan_pixels_reg(pix));
  clp_host_model clp_host_model_inst (.mclk(mclk), .bus_strobe(strobe),
    .register_select(sel), .read_write(rdwr), .host_data_bus_in(din),
    .host_data_bus_out(dout), .host_data_bus_oe(oe));
////////////////////////////////////////////////////////////////////////////////
  function automatic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    rnd = seed[7:0];
  endfunction
  function automatic [7:0] stepped(input [7:0] v, input up);
    stepped = up ? v + 8'h01 : v - 8'h01;
  endfunction
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic go(input logic s, input logic w, input logic [7:0] d);
    logic ok;
    clp_host_model_inst.xfer(s, w, d, 8, q);
    clp_host_model_inst.wait_idle(ok);
    chk("idle", {7'h00, ok}, 8'h01);
  endtask
  task automatic ins(input logic [7:0] c);
    go(1'b0, 1'b0, c);
  endtask
  task automatic finish_test();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #(20 * 30000);
    n_errors++;
    finish_test();
  end
////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge mclk);
    #1;
    reset = 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    chk("reset", {inc, bw, dsp, cur, blk, esh, two, tall}, 8'hc0);
    chk("reset counter", {busy, cnt}, 8'h00);
    ins(8'h3c);
    chk("fset", {5'h00, bw, two, tall}, 8'h07);
    for (k = 0; k < 8; k++) begin
      ins(8'h08 | k[7:0]);
      chk("dctl", {5'h00, dsp, cur, blk}, k[7:0]);
    end
    for (k = 3; k >= 0; k--) begin
      ins(8'h04 | k[7:0]);
      chk("entry", {6'h00, inc, esh}, k[7:0]);
    end
    ins(8'h06);
    // 4-bit: no status polls until back in 8-bit, they would split a byte
    clp_host_model_inst.xfer(1'b0, 1'b0, 8'h20, 8, q);
    repeat (SHORT + 20) @(posedge mclk);
    chk("width4", {7'h00, bw}, 8'h00);
    clp_host_model_inst.xfer(1'b0, 1'b0, 8'h30, 8, q);
    ins(8'h80);
    chk("width8", {5'h00, bw, two, tall}, 8'h06);
    clp_host_model_inst.xfer(1'b0, 1'b0, 8'h01, 8, q);
    repeat (LONG - 20) @(posedge mclk);
    #1;
    chk("clear busy", {7'h00, busy}, 8'h01);
    go(1'b1, 1'b1, 8'h00);
    chk("clear counter", {busy, cnt}, 8'h00);
    a = rnd() & 8'h1c;
    ins(8'h80 | a);
    go(1'b1, 1'b1, 8'h00);
    chk("clear fill", q, 8'h20);
    ins(8'h80 | a);
    for (k = 0; k < 3; k++) begin
      mem[k] = rnd();
      go(1'b1, 1'b0, mem[k]);
    end
    chk("write step", {busy, cnt}, a + 8'h03);
    ins(8'h80 | a);
    for (k = 0; k < 3; k++) begin
      go(1'b1, 1'b1, 8'h00);
      chk("read", q, mem[k]);
    end
    ins(8'h04);
    mem[3] = 8'h41 + (rnd() & 8'h0e);
    ins(8'h80 | mem[3]);
    go(1'b1, 1'b0, mem[1]);
    chk("decrement", {busy, cnt}, stepped(mem[3], 1'b0));
    ins(8'h80 | mem[3]);
    go(1'b1, 1'b1, 8'h00);
    chk("line two", q, mem[1]);
    ins(8'h06);
    mem[3] = rnd() & 8'h3e;
    ins(8'h40 | mem[3]);
    chk("glyph counter", {busy, cnt}, mem[3]);
    go(1'b1, 1'b0, mem[2]);
    chk("glyph step", {busy, cnt}, stepped(mem[3], 1'b1));
    ins(8'h40 | mem[3]);
    go(1'b1, 1'b1, 8'h00);
    chk("glyph read", q, mem[2]);
    ins(8'h85);
    ins(8'h14);
    chk("cursor right", {busy, cnt}, 8'h06);
    ins(8'h10);
    chk("cursor left", {busy, cnt}, 8'h05);
    ins(8'h18);
    chk("display shift", {dshift, cnt[0]}, 8'h03);
    ins(8'h02);
    chk("home", {dshift, cnt[0]}, 8'h00);
    ins(8'h80 | a);
    go(1'b1, 1'b1, 8'h00);
    chk("text kept", q, mem[0]);
    // glyph 3 row 2 in glyph ram, code 0b (bit 3 ignored) at column 2, a rom code at column 3
    ins(8'h5a);
    go(1'b1, 1'b0, mem[2]);
    ins(8'h82);
    go(1'b1, 1'b0, 8'h0b);
    go(1'b1, 1'b0, 8'h41);
    while (scan_reg != 9'h022) @(negedge mclk);
    @(posedge mclk);
    #1;
    chk("glyph pixels", {3'h0, pix}, {3'h0, mem[2][4:0]});
    while (scan_reg != 9'h093) @(negedge mclk);
    @(posedge mclk);
    #1;
    chk("short font row", {3'h0, pix}, 8'h00);
    ins(8'h07);
    go(1'b1, 1'b0, 8'h41);
    chk("shift on write", {dshift, cnt[0]}, 8'h03);
    ins(8'h06);
    clp_host_model_inst.xfer(1'b0, 1'b0, 8'h85, 8, q);
    clp_host_model_inst.xfer(1'b0, 1'b1, 8'h00, 8, q);
    chk("status", q, 8'h85);
    clp_host_model_inst.xfer(1'b0, 1'b0, 8'h90, 3, q);
    go(1'b0, 1'b1, 8'h00);
    chk("refused", {busy, cnt}, 8'h05);
    for (k = 0; k < 8; k++) begin
      clp_host_model_inst.xfer(1'b1, 1'b0, rnd(), 3, q);
    end
    chk("queue full", {7'h00, saw_full}, 8'h01);
    go(1'b0, 1'b1, 8'h00);
    chk("queue drained", {busy, 6'h00, wready}, 8'h01);
    finish_test();
  end
endmodule // test_clp_instruction_port
